//--- src/bas_map.svh
// register offsets, field positions, widths and reset values of the address scrambler
`ifndef BAS_MAP_SVH
`define BAS_MAP_SVH
// ----------------------------------------------------------------------------
// segment widths
// ----------------------------------------------------------------------------
`define BAS_CW        7
`define BAS_RW        8
`define BAS_BW        2
`define BAS_AW        17
`define BAS_NBANK     4
// counter bit positions: bank on top, then row, then column
`define BAS_COL_LSB   0
`define BAS_ROW_LSB   7
`define BAS_BANK_LSB  15
// ----------------------------------------------------------------------------
// apb byte offsets
// ----------------------------------------------------------------------------
`define BAS_OFF_CTRL  12'h000
`define BAS_OFF_STAT  12'h004
`define BAS_OFF_COLR  12'h008
`define BAS_OFF_BANKR 12'h00c
`define BAS_OFF_ROWLO 12'h010
`define BAS_OFF_ROWHI 12'h014
`define BAS_OFF_CNT   12'h018
`define BAS_OFF_PLACE 12'h040
`define BAS_OFF_SCR   12'h0c0
// ----------------------------------------------------------------------------
// control bit positions
// ----------------------------------------------------------------------------
`define BAS_C_START   0
`define BAS_C_SEG     1
`define BAS_C_MUX     2
`define BAS_C_SPORT   3
`define BAS_C_RPAD    4
`define BAS_C_CPAD    5
`define BAS_C_ABORT   6
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define BAS_RST_CTRL  6'h01
`define BAS_RST_COLHI 7'h7f
`define BAS_RST_BKHI  2'h3
`define BAS_RST_ROWHI 8'hff
`endif

//--- src/bas_pkg.sv
// shared types of the address scrambler
package bas_pkg;
  // sequencer states, gray along idle -> run -> done
  typedef enum logic [1:0] {
    BAS_IDLE = 2'b00,
    BAS_RUN  = 2'b01,
    BAS_DONE = 2'b11
  } bas_state_e;
  // boolean operators of a scramble function
  typedef enum logic [2:0] {
    BAS_AND = 3'h0, BAS_NAND = 3'h1, BAS_XOR = 3'h2, BAS_XNOR = 3'h3,
    BAS_OR  = 3'h4, BAS_NOR  = 3'h5, BAS_PASS = 3'h6
  } bas_op_e;
  // one pin scramble function: ((a op1 b) op2 c) with precedence applied
  typedef struct packed {
    logic       c_inv;
    logic [4:0] c_sel;
    logic       b_inv;
    logic [4:0] b_sel;
    logic       a_inv;
    logic [4:0] a_sel;
    bas_op_e    op2;
    bas_op_e    op1;
    logic       en;
  } bas_scr_s;
  // placement of one port bit: counter bit index, or mux slot
  typedef struct packed {
    logic       mux;
    logic [4:0] src;
  } bas_place_s;
  // memory address bundle
  typedef struct packed {
    logic [16:0] addr;
    logic        valid;
    logic        row_phase;
  } bas_mem_s;
endpackage : bas_pkg

//--- src/bas_address_scrambler.sv
// segmented address sequencer with port placement and pin scrambling
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "bas_map.svh"

module bas_address_scrambler (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // apb slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [11:0]          i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic                      o_pready,
  output logic      [31:0]          o_prdata,
  output logic                      o_pslverr,
  // advance pulse from the test controller
  input  wire logic                 i_adv,
  // memory address port
  output bas_pkg::bas_mem_s         o_mem
);
  import bas_pkg::*;

  // ----------------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------------
  // two-input operator
  function automatic logic op_f(input bas_op_e op, input logic x, input logic y);
    case (op)
      BAS_AND:  op_f = x & y;
      BAS_NAND: op_f = ~(x & y);
      BAS_XOR:  op_f = x ^ y;
      BAS_XNOR: op_f = ~(x ^ y);
      BAS_OR:   op_f = x | y;
      BAS_NOR:  op_f = ~(x | y);
      default:  op_f = x;
    endcase
  endfunction : op_f

  // operand fetch; out of range selects read as zero, inversion is the not
  function automatic logic opnd_f(input logic [16:0] c, input logic [4:0] s, input logic inv);
    opnd_f = ((s < 5'd17) ? c[s] : 1'b0) ^ inv;
  endfunction : opnd_f

  // evaluate one pin function over the whole counter
  function automatic logic scr_f(input bas_scr_s f, input logic [16:0] c);
    logic a;
    logic b;
    logic d;
    a = opnd_f(c, f.a_sel, f.a_inv);
    b = opnd_f(c, f.b_sel, f.b_inv);
    d = opnd_f(c, f.c_sel, f.c_inv);
    if (f.op1 == BAS_PASS) begin
      scr_f = a;
    end else if (f.op2 == BAS_PASS) begin
      scr_f = op_f(f.op1, a, b);
    end else if (f.op2[2:1] < f.op1[2:1]) begin
      scr_f = op_f(f.op1, a, op_f(f.op2, b, d)); // tighter op2 binds first
    end else begin
      scr_f = op_f(f.op2, op_f(f.op1, a, b), d); // left to right otherwise
    end
  endfunction : scr_f

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  bas_state_e       st_r,    st_nxt;     // sequencer state
  logic [5:0]       ctrl_r,  ctrl_nxt;   // control bits 6:1 kept, start is a pulse
  logic [6:0]       clo_r,   clo_nxt;    // column low
  logic [6:0]       chi_r,   chi_nxt;    // column high
  logic [1:0]       blo_r,   blo_nxt;    // bank low
  logic [1:0]       bhi_r,   bhi_nxt;    // bank high
  logic [7:0]       rlo_r [4], rlo_nxt [4];    // row low per bank
  logic [7:0]       rhi_r [4], rhi_nxt [4];    // row high per bank
  bas_place_s       plc_r [17], plc_nxt [17];  // placement per port bit
  bas_scr_s         scr_r [17], scr_nxt [17];  // one slot per bit, no duplicates
  logic [16:0]      cnt_r,   cnt_nxt;    // location sequencer {bank,row,col}
  logic             ph_r,    ph_nxt;     // 1 = row phase of a multiplexed address
  logic             done_r,  done_nxt;   // sticky pass complete
  bas_mem_s         mem_r,   mem_nxt;    // registered memory outputs
  logic [31:0]      rd_r,    rd_nxt;     // read data
  logic             err_r,   err_nxt;    // unmapped access

  // ----------------------------------------------------------------------------
  // configuration checks
  // ----------------------------------------------------------------------------
  logic        cover_err;  // a port bit points nowhere
  logic        dup_err;    // one counter bit placed twice
  logic        grp_err;    // partial row/column multiplexing
  logic        port_err;   // multiplexing on a multi-port memory
  logic        unused_w;   // a counter bit feeds no pin
  logic        mux_on;     // multiplexing requested
  logic        seg_on;     // segmented counting
  logic [16:0] used;
  logic [4:0]  nmux;

  // checks run continuously so software sees them before starting
  always_comb begin
    cover_err = 1'b0;
    dup_err   = 1'b0;
    nmux      = 5'd0;
    used      = '0;
    seg_on    = ctrl_r[`BAS_C_SEG - 1];
    for (int i = 0; i < 17; i++) begin
      if (plc_r[i].mux) begin
        nmux = nmux + 5'd1;
      end else if (plc_r[i].src > 5'd16) begin
        cover_err = 1'b1;
      end
      for (int j = 0; j < i; j++) begin
        if (!plc_r[i].mux && !plc_r[j].mux && plc_r[i].src == plc_r[j].src) begin
          dup_err = 1'b1;
        end
      end
      if (scr_r[i].en && seg_on) begin
        if (scr_r[i].a_sel < 5'd17) used[scr_r[i].a_sel] = 1'b1;
        if (scr_r[i].op1 != BAS_PASS && scr_r[i].b_sel < 5'd17) used[scr_r[i].b_sel] = 1'b1;
        if (scr_r[i].op2 != BAS_PASS && scr_r[i].c_sel < 5'd17) used[scr_r[i].c_sel] = 1'b1;
      end else begin
        used[i] = 1'b1;
      end
    end
    mux_on   = ctrl_r[`BAS_C_MUX - 1] && (nmux != 5'd0);
    // slots cover the whole column segment, or else no mux at all
    grp_err  = mux_on && (nmux < 5'(`BAS_CW));
    port_err = mux_on && (!ctrl_r[`BAS_C_SPORT - 1] || !seg_on);
    unused_w = ~&used;                                     // warn only
  end

  wire cfg_bad = cover_err | dup_err | grp_err | port_err;

  // ----------------------------------------------------------------------------
  // scrambling and placement
  // ----------------------------------------------------------------------------
  // physical value of every segment bit; index matches the placement index
  function automatic logic [16:0] phys_f(input logic [16:0] c);
    for (int i = 0; i < 17; i++) begin
      if (scr_r[i].en && ctrl_r[`BAS_C_SEG - 1]) begin
        phys_f[i] = scr_f(scr_r[i], c);
      end else begin
        phys_f[i] = c[i];
      end
    end
  endfunction : phys_f

  // drive the port from the physical bits
  function automatic logic [16:0] place_f(input logic [16:0] c, input logic row_ph);
    logic [16:0] p;
    logic [2:0]  k;
    p = phys_f(c);
    for (int i = 0; i < 17; i++) begin
      k = plc_r[i].src[2:0];
      if (plc_r[i].mux) begin
        // only row and column share pins, banks never do
        if (row_ph) begin
          place_f[i] = p[`BAS_ROW_LSB + k];
        end else if (k < 3'(`BAS_CW)) begin
          place_f[i] = p[`BAS_COL_LSB + k];
        end else begin
          place_f[i] = ctrl_r[`BAS_C_CPAD - 1];
        end
      end else if (plc_r[i].src < 5'd17) begin
        place_f[i] = p[plc_r[i].src];
      end else begin
        place_f[i] = 1'b0;
      end
    end
  endfunction : place_f

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  logic        wr;
  logic        rd;
  logic [4:0]  idx;
  logic [1:0]  bk;
  logic [7:0]  row;
  logic [6:0]  col;
  logic        last;

  // apb decode, sequencer, counter and output address
  always_comb begin
    st_nxt   = st_r;
    ctrl_nxt = ctrl_r;
    clo_nxt  = clo_r;
    chi_nxt  = chi_r;
    blo_nxt  = blo_r;
    bhi_nxt  = bhi_r;
    rlo_nxt  = rlo_r;
    rhi_nxt  = rhi_r;
    plc_nxt  = plc_r;
    scr_nxt  = scr_r;
    cnt_nxt  = cnt_r;
    ph_nxt   = ph_r;
    done_nxt = done_r;
    rd_nxt   = rd_r;
    err_nxt  = err_r;
    wr       = i_psel & i_penable & i_pwrite;
    rd       = i_psel & ~i_penable;
    idx      = 5'(i_paddr[11:2] - {2'b00, i_paddr[11:8] >= 4'h1 ? 8'h30 : 8'h10});
    bk       = cnt_r[16:15];
    row      = cnt_r[14:7];
    col      = cnt_r[6:0];
    last     = 1'b0;
    // setup phase: latch read data and the slave error for the access phase
    if (rd) begin
      rd_nxt  = 32'h0;
      err_nxt = 1'b0;
      case (i_paddr)
        `BAS_OFF_CTRL:  rd_nxt = {25'h0, 1'b0, ctrl_r};
        `BAS_OFF_STAT:  rd_nxt = {25'h0, unused_w, port_err, grp_err, dup_err,
                                  cover_err, done_r, st_r == BAS_RUN};
        `BAS_OFF_COLR:  rd_nxt = {16'h0, 1'b0, chi_r, 1'b0, clo_r};
        `BAS_OFF_BANKR: rd_nxt = {24'h0, 2'b00, bhi_r, 2'b00, blo_r};
        `BAS_OFF_ROWLO: rd_nxt = {rlo_r[3], rlo_r[2], rlo_r[1], rlo_r[0]};
        `BAS_OFF_ROWHI: rd_nxt = {rhi_r[3], rhi_r[2], rhi_r[1], rhi_r[0]};
        `BAS_OFF_CNT:   rd_nxt = {15'h0, cnt_r};
        default: begin
          if (i_paddr >= `BAS_OFF_PLACE && i_paddr < `BAS_OFF_PLACE + 12'h044) begin
            rd_nxt = {26'h0, plc_r[idx]};
          end else if (i_paddr >= `BAS_OFF_SCR && i_paddr < `BAS_OFF_SCR + 12'h044) begin
            rd_nxt = {7'h0, scr_r[idx]};
          end else begin
            err_nxt = 1'b1;                   // unmapped address answers with an error
          end
        end
      endcase
    end
    // access phase: writes land here; config is frozen while running
    if (wr && !err_r && st_r != BAS_RUN) begin
      case (i_paddr)
        `BAS_OFF_CTRL:  ctrl_nxt = i_pwdata[6:1];
        `BAS_OFF_COLR:  begin clo_nxt = i_pwdata[6:0]; chi_nxt = i_pwdata[14:8]; end
        `BAS_OFF_BANKR: begin blo_nxt = i_pwdata[1:0]; bhi_nxt = i_pwdata[5:4]; end
        `BAS_OFF_ROWLO: for (int b = 0; b < 4; b++) rlo_nxt[b] = i_pwdata[8*b +: 8];
        `BAS_OFF_ROWHI: for (int b = 0; b < 4; b++) rhi_nxt[b] = i_pwdata[8*b +: 8];
        `BAS_OFF_CNT, `BAS_OFF_STAT: ;
        default: begin
          if (i_paddr < `BAS_OFF_SCR) plc_nxt[idx] = i_pwdata[5:0];
          else scr_nxt[idx] = i_pwdata[24:0];
        end
      endcase
    end
    // sequencer
    case (st_r)
      BAS_IDLE, BAS_DONE: begin
        if (wr && !err_r && i_paddr == `BAS_OFF_CTRL && i_pwdata[`BAS_C_START] && !cfg_bad) begin
          st_nxt   = BAS_RUN;
          done_nxt = 1'b0;
          ph_nxt   = mux_on;
          // judged on the stored control, like the checks: write config first
          cnt_nxt  = seg_on ? {blo_r, rlo_r[blo_r], clo_r} : 17'h0;
        end
      end
      BAS_RUN: begin
        if (wr && i_paddr == `BAS_OFF_CTRL && i_pwdata[`BAS_C_ABORT]) begin
          st_nxt = BAS_IDLE;
        end else if (i_adv && mux_on && ph_r) begin
          ph_nxt = 1'b0;                       // row half sent, column half next
        end else if (i_adv) begin
          ph_nxt = mux_on;
          if (!seg_on) begin
            last    = &cnt_r;
            cnt_nxt = cnt_r + 17'h1;
          end else if (col < chi_r) begin      // column first
            cnt_nxt[6:0] = col + 7'h1;
          end else begin
            cnt_nxt[6:0] = clo_r;
            if (row < rhi_r[bk]) begin         // row limit of this bank
              cnt_nxt[14:7] = row + 8'h1;
            end else begin
              // carry into bank, row restarts at the new bank's low
              cnt_nxt[16:15] = (bk < bhi_r) ? bk + 2'h1 : blo_r;
              cnt_nxt[14:7]  = rlo_r[cnt_nxt[16:15]];
              last           = !(bk < bhi_r);
            end
          end
          if (last) begin
            st_nxt   = BAS_DONE;
            done_nxt = 1'b1;
          end
        end
      end
      default: st_nxt = BAS_IDLE;
    endcase
    mem_nxt.addr      = place_f(cnt_nxt, ph_nxt);     // bank on the high pins
    mem_nxt.valid     = (st_nxt == BAS_RUN);
    mem_nxt.row_phase = ph_nxt & (st_nxt == BAS_RUN);
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  // all state updates on every edge; constants only under reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r   <= BAS_IDLE;
      ctrl_r <= `BAS_RST_CTRL;
      clo_r  <= 7'h0;
      chi_r  <= `BAS_RST_COLHI;
      blo_r  <= 2'h0;
      bhi_r  <= `BAS_RST_BKHI;
      for (int b = 0; b < 4; b++) begin
        rlo_r[b] <= 8'h0;
        rhi_r[b] <= `BAS_RST_ROWHI;
      end
      for (int i = 0; i < 17; i++) begin
        plc_r[i] <= '{mux: 1'b0, src: 5'(i)};
        scr_r[i] <= '0;
      end
      cnt_r  <= 17'h0;
      ph_r   <= 1'b0;
      done_r <= 1'b0;
      mem_r  <= '0;
      rd_r   <= 32'h0;
      err_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      ctrl_r <= ctrl_nxt;
      clo_r  <= clo_nxt;
      chi_r  <= chi_nxt;
      blo_r  <= blo_nxt;
      bhi_r  <= bhi_nxt;
      rlo_r  <= rlo_nxt;
      rhi_r  <= rhi_nxt;
      plc_r  <= plc_nxt;
      scr_r  <= scr_nxt;
      cnt_r  <= cnt_nxt;
      ph_r   <= ph_nxt;
      done_r <= done_nxt;
      mem_r  <= mem_nxt;
      rd_r   <= rd_nxt;
      err_r  <= err_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  // zero wait states: read data was latched in the setup cycle
  assign o_pready  = 1'b1;
  assign o_prdata  = rd_r;
  assign o_pslverr = err_r & i_psel & i_penable;
  assign o_mem     = mem_r;
endmodule : bas_address_scrambler

//--- dv/bas_address_scrambler_chk.sv
// port-level assertions for the address scrambler
`timescale 1ns/10ps
module bas_address_scrambler_chk (
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_rst,
  // apb slave
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [11:0]       i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic              o_pready,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pslverr,
  // sequencer side
  input wire logic              i_adv,
  input wire bas_pkg::bas_mem_s o_mem
);
  import bas_pkg::*;
  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  wire logic wr_acc;   // a write in its access phase
  wire logic start_wr; // a write of the start bit to control
  assign wr_acc   = i_psel & i_penable & i_pwrite;
  assign start_wr = wr_acc & (i_paddr == 12'h000) & i_pwdata[0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  ready_high_a: assert property (o_pready)
    else $error("pready low");
  err_phase_a: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("pslverr outside access phase");
  addr_hold_a: assert property (
    o_mem.valid && !i_adv && !wr_acc |=> $stable(o_mem.addr))
    else $error("address moved without advance");
  run_start_a: assert property ($rose(o_mem.valid) |-> $past(start_wr))
    else $error("run began without start write");
  run_stop_a: assert property (
    $fell(o_mem.valid) |-> $past(i_adv) || $past(wr_acc))
    else $error("run ended without advance or abort");
  phase_valid_a: assert property (o_mem.row_phase |-> o_mem.valid)
    else $error("row half shown while idle");
  phase_flip_a: assert property (
    o_mem.valid && o_mem.row_phase && i_adv |=> o_mem.valid && !o_mem.row_phase)
    else $error("column half did not follow row half");
  rdata_hold_a: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
    else $error("read data changed outside setup");
endmodule : bas_address_scrambler_chk

bind bas_address_scrambler bas_address_scrambler_chk u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .i_adv(i_adv), .o_mem(o_mem));

//--- dv/bas_mem_model.sv
// memory-side model: logs each presented address and acknowledges it
`timescale 1ns/10ps
module bas_mem_model (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // bench control
  input  wire logic [3:0]        i_gap,
  input  wire logic              i_clr,
  // address port
  input  wire bas_pkg::bas_mem_s i_mem,
  output logic                   o_adv
);
  import bas_pkg::*;
  logic [17:0] seen [0:63]; // {row half, address} in arrival order
  int          n_seen;      // how many were logged
  logic [3:0]  wait_r;      // cycles spent on the current address
  // one pulse per address, after i_gap idle cycles, so none is skipped
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_adv  <= 1'b0;
      wait_r <= '0;
      n_seen <= 0;
    end else if (i_clr) begin
      n_seen <= 0;
    end else if (o_adv) begin
      o_adv  <= 1'b0;
      wait_r <= '0;
    end else if (i_mem.valid) begin
      if (wait_r == i_gap) begin
        seen[n_seen[5:0]] <= {i_mem.row_phase, i_mem.addr};
        n_seen            <= n_seen + 1;
        o_adv             <= 1'b1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule : bas_mem_model

//--- dv/tb_bas_address_scrambler.sv
// self-checking bench for the address scrambler
`timescale 1ns/10ps
module tb_bas_address_scrambler;
  import bas_pkg::*;
  logic        i_clk, i_rst, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, q;
  logic        o_pready, o_pslverr, adv, clr, e;
  logic [3:0]  gap;
  bas_mem_s    mem_bus;
  int          fail_count, num_checks;
  int          pl [3] = '{32, 32, 1};        // port bit 0: mux slot 0, or source 1
  int          ct [3] = '{7, 15, 3};         // control word tried
  int          mk [3] = '{32, 16, 8};        // error flag expected

  bas_address_scrambler DUT (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_adv(adv), .o_mem(mem_bus));
  bas_mem_model u_mem (.i_clk(i_clk), .i_rst(i_rst), .i_gap(gap), .i_clr(clr),
    .i_mem(mem_bus), .o_adv(adv));

  always #25 i_clk = ~i_clk;
  // ------------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    q = o_prdata;
    e = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask : rd
  // bank on top, row, column; mode 1 scrambles pin 0, mode 2 swaps pins 0 and 7
  // mode 3 is a column half with the pad on pin 7, mode 4 a row half on pins 7:0
  function automatic logic [16:0] exp_addr(input int b, r, c, mode);
    logic [16:0] a;
    logic        t;
    a = {b[1:0], r[7:0], c[6:0]};
    if (mode == 1) a[0] = ~a[0] ^ (a[1] & a[7]);
    if (mode == 2) begin
      t    = a[0];
      a[0] = a[7];
      a[7] = t;
    end
    if (mode == 3) a[7] = 1'b1;
    if (mode == 4) a[7:0] = r[7:0];
    return a;
  endfunction : exp_addr
  // one full run; bank 0 rows 0..2, bank 1 row 1 only, columns 0..3
  task automatic sweep(input int mode, input logic [3:0] g, input logic [31:0] ctl);
    int k;
    int n;
    gap <= g;
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    apb(1'b1, 12'h000, ctl); // config first, the start is judged against it
    apb(1'b1, 12'h000, ctl | 32'h1);
    n = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end while (q[1] !== 1'b1 && n < 100);
    chk(q & 32'h3, 32'h2);
    chk(32'(u_mem.n_seen), 32'(16 * (mode / 3 + 1)));
    k = 0;
    for (int b = 0; b < 2; b++)
      for (int r = b; r <= 2 - b; r++)
        for (int c = 0; c < 4; c++)
          for (int h = mode / 3; h >= 0; h--) begin
            chk(32'(u_mem.seen[k]), {14'h0, h[0], exp_addr(b, r, c, mode + h)});
            k++;
          end
  endtask : sweep
  task give_verdict;
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------------
  initial begin
    #1000000;
    fail_count++;
    give_verdict;
  end
  initial begin
    {i_clk, i_psel, i_penable, i_pwrite, clr} = '0;
    {i_paddr, i_pwdata, gap} = '0;
    i_rst = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(12'h000, 32'hffffffff, 32'h1);
    rd(12'h008, 32'hffffffff, 32'h7f00);
    rd(12'h00c, 32'hffffffff, 32'h30);
    rd(12'h014, 32'hffffffff, 32'hffffffff);
    rd(12'h004, 32'h3f, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk(32'(e), 32'h1);
    // refused starts: mux without single port, partial mux group, duplicate source
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 12'h040, pl[i]);
      apb(1'b1, 12'h000, ct[i] - 1);
      apb(1'b1, 12'h000, ct[i]);
      rd(12'h004, mk[i], mk[i]);
      @(posedge i_clk);
      chk(32'(mem_bus.valid), 32'h0);
      apb(1'b1, 12'h040, 32'h0);
      apb(1'b1, 12'h000, 32'h2);
    end
    apb(1'b1, 12'h008, 32'h300);
    apb(1'b1, 12'h00c, 32'h10);
    apb(1'b1, 12'h010, 32'h100);
    apb(1'b1, 12'h014, 32'hffff0102);
    sweep(0, 4'h0, 32'h2);
    apb(1'b1, 12'h0c0, 32'h383005);
    sweep(1, 4'h2, 32'h2);
    apb(1'b1, 12'h0c0, 32'h0);
    apb(1'b1, 12'h040, 32'h7);
    apb(1'b1, 12'h05c, 32'h0);
    sweep(2, 4'h0, 32'h2);
    // pins 7:0 shared: row bits in the row half, column bits and pad after
    for (int i = 0; i < 8; i++) apb(1'b1, 12'(12'h040 + 4 * i), 32'h20 + i);
    sweep(3, 4'h1, 32'h2e);
    give_verdict;
  end
endmodule : tb_bas_address_scrambler
